// [design/fps_cmd_handler.v]
/*
  flash programming command handler with protection flags, a small
  flip-flop flash array, a self programming port and a two-entry answer
  buffer. assumes the programmer drives clk and reset_n, presents one
  command at a time on the cmd_* ports and drains answers on resp_*.
*/
`include "fps_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module fps_cmd_handler #(
  parameter ADDR_W = 4,
  parameter BLK_W  = 2
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              prog_attach,
  input  wire              cmd_valid,
  output wire              cmd_ready,
  input  wire [2:0]        cmd_code,
  input  wire [ADDR_W-1:0] cmd_addr_lo,
  input  wire [ADDR_W-1:0] cmd_addr_hi,
  input  wire [BLK_W-1:0]  cmd_block,
  input  wire [7:0]        cmd_data,
  input  wire [2:0]        cmd_flags,
  output wire              resp_valid,
  input  wire              resp_ready,
  output wire [7:0]        resp_code,
  output wire [7:0]        resp_data,
  input  wire              sp_valid,
  output wire              sp_ready,
  input  wire              sp_erase,
  input  wire [ADDR_W-1:0] sp_addr,
  input  wire [7:0]        sp_data,
  output wire              prog_mode,
  output wire [2:0]        flags_recorded,
  output wire [2:0]        flags_enforced
);

  localparam DEPTH  = 1 << ADDR_W;
  localparam S_IDLE = 3'b001;
  localparam S_RUN  = 3'b010;
  localparam S_VER  = 3'b100;

  reg  [2:0]        state_reg;
  reg  [ADDR_W-1:0] ptr_reg;
  reg  [ADDR_W-1:0] start_reg;
  reg  [ADDR_W-1:0] end_reg;
  reg  [2:0]        op_reg;
  reg  [7:0]        data_reg;
  reg  [7:0]        acc_reg;
  reg               ok_reg;
  reg  [2:0]        rec_reg;
  reg  [2:0]        enf_reg;
  reg               mode_reg;
  reg               sync1_reg;
  reg               sync2_reg;
  reg               sync3_reg;
  reg               attach_reg;
  reg  [15:0]       buf0_reg;
  reg  [15:0]       buf1_reg;
  reg               wptr_reg;
  reg               rptr_reg;
  reg  [1:0]        count_reg;
  wire [DEPTH*8-1:0] mem_flat;

  // attach pin: three flops, change accepted once the last two agree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      sync3_reg  <= 1'b0;
      attach_reg <= 1'b0;
    end else begin
      sync1_reg <= prog_attach;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        attach_reg <= sync3_reg;
    end
  end

  // command acceptance; work starts only from a programmer command
  wire idle      = state_reg[0];
  wire buf_room  = (count_reg != 2'd2);
  assign cmd_ready = attach_reg & idle & buf_room;
  wire take      = cmd_valid & cmd_ready;

  // flags in force: latched copy in mode, recorded copy at entry
  wire [2:0] eff = mode_reg ? enf_reg : rec_reg;
  wire prot_batch = eff[`FPS_FLAG_BATCH];
  wire prot_block = eff[`FPS_FLAG_BLOCK];
  wire prot_write = eff[`FPS_FLAG_WRITE];

  wire ref_batch = prot_batch;
  wire ref_block = prot_batch | prot_block | prot_write;
  wire ref_write = prot_write;
  wire bad_range = (cmd_addr_hi < cmd_addr_lo);

  wire is_batch = (cmd_code == `FPS_CMD_BATCH_ERASE);
  wire is_block = (cmd_code == `FPS_CMD_BLOCK_ERASE);
  wire is_write = (cmd_code == `FPS_CMD_WRITE);
  wire is_csum  = (cmd_code == `FPS_CMD_CHECKSUM);
  wire is_blank = (cmd_code == `FPS_CMD_BLANK_CHECK);
  wire is_sec   = (cmd_code == `FPS_CMD_SECURITY);
  wire is_range = is_write | is_csum;
  wire is_multi = is_blank | (is_range & ~bad_range & ~(is_write & ref_write));

  // self programming is locked out while the programmer owns the array
  assign sp_ready = idle & ~mode_reg & ~attach_reg;
  wire sp_do = sp_valid & sp_ready;

  // array write controls; refused commands produce none of these
  wire wipe_all = take & is_batch & ~ref_batch;
  wire blk_cmd  = take & is_block & ~ref_block;
  wire blk_sp   = sp_do & sp_erase;
  wire wipe_blk = blk_cmd | blk_sp;
  wire [BLK_W-1:0] wipe_idx = blk_cmd ? cmd_block
                                      : sp_addr[ADDR_W-1 -: BLK_W];
  wire run_wr   = state_reg[1] & (op_reg == `FPS_CMD_WRITE);
  wire prog_en  = run_wr | (sp_do & ~sp_erase);
  wire [ADDR_W-1:0] prog_addr = run_wr ? ptr_reg : sp_addr;
  wire [7:0]        prog_data = run_wr ? data_reg : sp_data;

  // flash cells: programming only clears bits, so data already written
  // cannot have any cleared bit set to one again without an erase
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_cell
      reg [7:0] cell_reg;
      // a genvar cannot be sliced, so its value goes through a parameter
      localparam integer CELL = gi;
      wire [ADDR_W-1:0] my_addr = CELL[ADDR_W-1:0];
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
          cell_reg <= `FPS_ERASED;
        else if (wipe_all ||
                 (wipe_blk && my_addr[ADDR_W-1 -: BLK_W] == wipe_idx))
          cell_reg <= `FPS_ERASED;
        else if (prog_en && prog_addr == my_addr)
          cell_reg <= cell_reg & prog_data;
      end
      assign mem_flat[gi*8 +: 8] = cell_reg;
    end
  endgenerate

  wire [7:0] mem_at  = mem_flat[{ptr_reg, 3'b000} +: 8];
  wire       at_end  = (ptr_reg == end_reg);
  wire       byte_ok = (mem_at == data_reg);
  wire       byte_ff = (mem_at == `FPS_ERASED);
  wire [7:0] acc_sum = acc_reg + mem_at;

  // answer selection for one-cycle commands and for walk completion
  reg        push_en;
  reg [15:0] push_word;
  always @* begin
    push_en   = 1'b0;
    push_word = {`FPS_RESP_NAK, 8'h00};
    if (take && !is_multi) begin
      push_en = 1'b1;
      if ((is_batch && !ref_batch) || (is_block && !ref_block) || is_sec)
        push_word = {`FPS_RESP_ACK, 8'h00};
    end else if (state_reg[1] && at_end && op_reg != `FPS_CMD_WRITE) begin
      push_en = 1'b1;
      if (op_reg == `FPS_CMD_CHECKSUM)
        push_word = {`FPS_RESP_ACK, acc_sum};
      else
        push_word = {`FPS_RESP_ACK, 7'h00, ok_reg & byte_ff};
    end else if (state_reg[2] && at_end) begin
      push_en = 1'b1;
      if (ok_reg && byte_ok)
        push_word = {`FPS_RESP_ACK, 8'h00};
    end
  end

  // command sequencer: walks the address range one byte per cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      ptr_reg   <= {ADDR_W{1'b0}};
      start_reg <= {ADDR_W{1'b0}};
      end_reg   <= {ADDR_W{1'b0}};
      op_reg    <= 3'h0;
      data_reg  <= 8'h00;
      acc_reg   <= 8'h00;
      ok_reg    <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (take && is_multi) begin
            state_reg <= S_RUN;
            op_reg    <= cmd_code;
            data_reg  <= cmd_data;
            acc_reg   <= 8'h00;
            ok_reg    <= 1'b1;
            ptr_reg   <= is_blank ? {ADDR_W{1'b0}} : cmd_addr_lo;
            start_reg <= is_blank ? {ADDR_W{1'b0}} : cmd_addr_lo;
            end_reg   <= is_blank ? {ADDR_W{1'b1}} : cmd_addr_hi;
          end
        end
        S_RUN: begin
          acc_reg <= acc_sum;
          ok_reg  <= ok_reg & byte_ff;
          if (at_end) begin
            if (op_reg == `FPS_CMD_WRITE) begin
              state_reg <= S_VER;
              ptr_reg   <= start_reg;
              ok_reg    <= 1'b1;
            end else
              state_reg <= S_IDLE;
          end else
            ptr_reg <= ptr_reg + 1'b1;
        end
        S_VER: begin
          ok_reg <= ok_reg & byte_ok;
          if (at_end)
            state_reg <= S_IDLE;
          else
            ptr_reg <= ptr_reg + 1'b1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // mode entry and protection flags; reset models the factory state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= 1'b0;
      rec_reg  <= `FPS_FLAGS_FACTORY;
      enf_reg  <= `FPS_FLAGS_FACTORY;
    end else begin
      if (!attach_reg)
        mode_reg <= 1'b0;
      else if (take && !mode_reg) begin
        mode_reg <= 1'b1;
        enf_reg  <= rec_reg;
      end
      if (take && is_sec)
        rec_reg <= rec_reg | cmd_flags;
      else if (wipe_all && !rec_reg[`FPS_FLAG_BATCH]) begin
        // batch erase cancels block and write bans, but not once the batch
        // ban is recorded, even before it is enforced: then all stay
        rec_reg[`FPS_FLAG_BLOCK] <= 1'b0;
        rec_reg[`FPS_FLAG_WRITE] <= 1'b0;
        enf_reg[`FPS_FLAG_BLOCK] <= 1'b0;
        enf_reg[`FPS_FLAG_WRITE] <= 1'b0;
      end
    end
  end

  // two-entry answer buffer: a stalled reader holds off new commands
  wire pop = resp_valid & resp_ready;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf0_reg  <= 16'h0000;
      buf1_reg  <= 16'h0000;
      wptr_reg  <= 1'b0;
      rptr_reg  <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      if (push_en) begin
        if (wptr_reg)
          buf1_reg <= push_word;
        else
          buf0_reg <= push_word;
        wptr_reg <= ~wptr_reg;
      end
      if (pop)
        rptr_reg <= ~rptr_reg;
      if (push_en && !pop)
        count_reg <= count_reg + 2'd1;
      else if (pop && !push_en)
        count_reg <= count_reg - 2'd1;
    end
  end

  assign resp_valid     = (count_reg != 2'd0);
  assign resp_code      = rptr_reg ? buf1_reg[15:8] : buf0_reg[15:8];
  assign resp_data      = rptr_reg ? buf1_reg[7:0]  : buf0_reg[7:0];
  assign prog_mode      = mode_reg;
  assign flags_recorded = rec_reg;
  assign flags_enforced = enf_reg;

endmodule // fps_cmd_handler

`default_nettype wire

// [design/fps_consts.vh]
/*
  constants for the flash programming command handler: command codes,
  answer codes, protection flag positions and the erased byte value.
  assumes it is included by the handler module and the top bench.
*/
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH

// command codes on cmd_code
`define FPS_CMD_BATCH_ERASE 3'h1
`define FPS_CMD_BLOCK_ERASE 3'h2
`define FPS_CMD_WRITE       3'h3
`define FPS_CMD_CHECKSUM    3'h4
`define FPS_CMD_BLANK_CHECK 3'h5
`define FPS_CMD_SECURITY    3'h6

// answer codes on resp_code
`define FPS_RESP_ACK        8'h06
`define FPS_RESP_NAK        8'h15

// protection flag bit positions and factory flags value
`define FPS_FLAG_BATCH      0
`define FPS_FLAG_BLOCK      1
`define FPS_FLAG_WRITE      2
`define FPS_FLAGS_FACTORY   3'h0

// value of an erased byte
`define FPS_ERASED          8'hff

`endif

// [tb/fps_chk_sva.sv]
/* checker for the flash programming command handler ports.
   assumes it is bound to every fps_cmd_handler instance. */
`timescale 1ns/1ns
`default_nettype none
module fps_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic [2:0] cmd_flags,
  input wire logic       resp_valid,
  input wire logic       resp_ready,
  input wire logic [7:0] resp_code,
  input wire logic [7:0] resp_data,
  input wire logic       prog_mode,
  input wire logic [2:0] flags_recorded,
  input wire logic [2:0] flags_enforced
);
  // a take of a one-cycle command into an empty buffer shows its answer at the head next cycle
  wire logic take = cmd_valid & cmd_ready;
  wire logic solo = take & !resp_valid & prog_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  resp_hold_a: assert property (resp_valid && !resp_ready |=> resp_valid &&
    $stable(resp_code) && $stable(resp_data)) else $error("answer moved");
  sec_record_a: assert property (take && cmd_code == 3'h6 |=>
    (flags_recorded & $past(cmd_flags)) == $past(cmd_flags)) else $error("flags lost");
  sec_later_a: assert property (take && cmd_code == 3'h6 && prog_mode
    |=> $stable(flags_enforced)) else $error("flags early");
  batch_sticky_a: assert property (flags_recorded[0] |=>
    (flags_recorded & $past(flags_recorded)) == $past(flags_recorded))
    else $error("flag cleared");
  batch_nak_a: assert property (solo && cmd_code == 3'h1 && flags_enforced[0]
    |=> resp_valid && resp_code == 8'h15) else $error("batch not refused");
  block_nak_a: assert property (solo && cmd_code == 3'h2 && |flags_enforced
    |=> resp_valid && resp_code == 8'h15) else $error("block not refused");
  write_nak_a: assert property (solo && cmd_code == 3'h3 && flags_enforced[2]
    |=> resp_valid && resp_code == 8'h15) else $error("write not refused");
  illegal_nak_a: assert property (take && !resp_valid && cmd_code[2:1] ==
    {2{cmd_code[0]}} |=> resp_valid && resp_code == 8'h15) else $error("bad code");
  cover property (solo && cmd_code == 3'h1 && flags_enforced[0]);
  cover property (solo && cmd_code == 3'h2 && flags_enforced[2]);
  cover property (resp_valid && !resp_ready);
endmodule // fps_chk
bind fps_cmd_handler fps_chk fps_chk_inst (.clk, .reset_n, .cmd_valid,
  .cmd_ready, .cmd_code, .cmd_flags, .resp_valid, .resp_ready, .resp_code,
  .resp_data, .prog_mode, .flags_recorded, .flags_enforced);
`default_nettype wire

// [tb/fps_cmd_handler_test.sv]
/* top bench for the flash programming command handler.
   assumes the design, its constants header and the sink model. */
`include "fps_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module fps_cmd_handler_test;
  logic       clk = 0, reset_n = 0, prog_attach = 0, stall = 0, sp_erase = 0;
  logic       cmd_valid = 0, sp_valid = 0;
  logic [2:0] cmd_code = '0, cmd_flags = '0;
  logic [3:0] cmd_addr_lo = '0, cmd_addr_hi = '0, sp_addr = '0;
  logic [1:0] cmd_block = '0;
  logic [7:0] cmd_data = '0, sp_data = '0;
  wire        cmd_ready, resp_valid, resp_ready, sp_ready, prog_mode;
  wire  [7:0] resp_code, resp_data, ans_cnt, ans_code, ans_data;
  wire  [2:0] flags_recorded, flags_enforced;
  int         failures = 0, checks_done = 0;
  localparam [7:0] ack = `FPS_RESP_ACK, nak = `FPS_RESP_NAK;
  fps_cmd_handler fps_cmd_handler_inst (.clk, .reset_n, .prog_attach,
    .cmd_valid, .cmd_ready, .cmd_code, .cmd_addr_lo, .cmd_addr_hi,
    .cmd_block, .cmd_data, .cmd_flags, .resp_valid, .resp_ready, .resp_code,
    .resp_data, .sp_valid, .sp_ready, .sp_erase, .sp_addr, .sp_data,
    .prog_mode, .flags_recorded, .flags_enforced);
  fps_prog_sink fps_prog_sink_inst (.clk, .reset_n, .resp_valid, .resp_code,
    .resp_data, .stall, .resp_ready, .ans_cnt, .ans_code, .ans_data);
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input string n, input [7:0] e, input [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // fields held from a falling edge until the take edge, then dropped;
  // a free edge first, so back-to-back calls never toggle valid at once
  task send(input [2:0] c, input [3:0] lo, hi, input [7:0] d,
            input [2:0] f, input w);
    int k;
    logic [7:0] n;
    @(negedge clk);
    n = ans_cnt;
    for (k = 0; k < 99 && cmd_ready !== 1'b1; k++) @(negedge clk);
    {cmd_code, cmd_addr_lo, cmd_addr_hi, cmd_data} = {c, lo, hi, d};
    {cmd_flags, cmd_block, cmd_valid} = {f, lo[3:2], 1'b1};
    @(negedge clk);
    cmd_valid = 0;
    for (k = 0; k < 99 && w && ans_cnt == n; k++) @(negedge clk);
    if (w) chk("answer", n + 8'h1, ans_cnt);
  endtask
  task run(input [2:0] c, input [3:0] lo, hi, input [7:0] d,
           input [2:0] f, input [7:0] e);
    send(c, lo, hi, d, f, 1);
    chk("code", e, ans_code);
  endtask
  // attach waits for command ready, detach for self programming ready
  task link(input a);
    int k;
    prog_attach = a;
    for (k = 0; k < 99 && (a ? cmd_ready : sp_ready) !== 1'b1; k++)
      @(negedge clk);
  endtask
  task t_factory;
    chk("rec", 0, flags_recorded);
    chk("mode", 0, prog_mode);
    run(3'h3, 0, 7, 8'h5a, 0, ack);
    chk("mode", 1, prog_mode);
    run(3'h4, 0, 7, 0, 0, ack);
    chk("sum", 8'hd0, ans_data);
    run(3'h5, 0, 0, 0, 0, ack);
    chk("blank", 0, ans_data);
    run(3'h7, 0, 0, 0, 0, nak);
    run(3'h0, 0, 0, 0, 0, nak);
    run(3'h3, 3, 2, 0, 0, nak);
  endtask
  // two answers held back fill the buffer; nothing may be lost
  task t_buffer;
    int k;
    logic [7:0] n;
    n = ans_cnt;
    stall = 1;
    send(3'h7, 0, 0, 0, 0, 0);
    send(3'h7, 0, 0, 0, 0, 0);
    @(negedge clk);
    chk("ready", 0, cmd_ready);
    stall = 0;
    for (k = 0; k < 9 && ans_cnt != n + 8'h2; k++) @(negedge clk);
    chk("drained", n + 8'h2, ans_cnt);
  endtask
  task t_erase;
    run(3'h2, 0, 0, 0, 0, ack);
    run(3'h4, 0, 7, 0, 0, ack);
    chk("sum", 8'h64, ans_data);
    run(3'h1, 0, 0, 0, 0, ack);
    run(3'h5, 0, 0, 0, 0, ack);
    chk("blank", 1, ans_data);
  endtask
  task t_protect;
    run(3'h6, 0, 0, 0, 3'h6, ack);
    run(3'h2, 0, 0, 0, 0, ack);
    link(0);
    link(1);
    run(3'h3, 0, 0, 0, 0, nak);
    run(3'h4, 0, 0, 0, 0, ack);
    chk("kept", 8'hff, ans_data);
    chk("enf", 6, flags_enforced);
    run(3'h2, 0, 0, 0, 0, nak);
    run(3'h1, 0, 0, 0, 0, ack);
    chk("rec", 0, flags_recorded);
  endtask
  task t_lock;
    run(3'h6, 0, 0, 0, 3'h3, ack);
    // batch ban recorded but not yet enforced: erase runs, bans stay
    run(3'h1, 0, 0, 0, 0, ack);
    chk("rec", 3, flags_recorded);
    link(0);
    link(1);
    run(3'h1, 0, 0, 0, 0, nak);
    run(3'h2, 0, 0, 0, 0, nak);
    run(3'h3, 4, 4, 8'h00, 0, ack);
    run(3'h3, 4, 4, 8'hff, 0, nak);
    run(3'h4, 4, 4, 0, 0, ack);
    chk("sum", 8'h00, ans_data);
    run(3'h6, 0, 0, 0, 3'h0, ack);
    chk("rec", 3, flags_recorded);
  endtask
  // one self programming strobe, a free edge before it
  task sp_op(input e, input [3:0] a, input [7:0] d);
    @(negedge clk);
    {sp_erase, sp_addr, sp_data, sp_valid} = {e, a, d, 1'b1};
    @(negedge clk);
    sp_valid = 0;
  endtask
  // self erase and write go through while erase bans are recorded
  task t_self;
    link(0);
    sp_op(1, 4'h4, 8'h00);
    sp_op(0, 4'h5, 8'h3c);
    link(1);
    run(3'h4, 4, 5, 0, 0, ack);
    chk("sum", 8'h3b, ans_data);
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // inputs move on falling edges only
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1;
    link(1);
    t_factory;
    t_buffer;
    t_erase;
    t_protect;
    t_lock;
    t_self;
    conclude;
  end
  // whole run needs well under 2000 cycles
  initial begin
    #400000;
    failures++;
    conclude;
  end
endmodule // fps_cmd_handler_test
`default_nettype wire

// [tb/fps_prog_sink.sv]
/* answer side of the programmer: takes answers, may stall.
   assumes the handler's clock and reset. */
`timescale 1ns/1ns
`default_nettype none
module fps_prog_sink (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_code,
  input  wire logic [7:0] resp_data,
  input  wire logic       stall,
  output logic            resp_ready,
  output logic      [7:0] ans_cnt,
  output logic      [7:0] ans_code,
  output logic      [7:0] ans_data
);
  // a slow programmer just withholds ready
  assign resp_ready = !stall;
  // count answers and keep the latest, one per command
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {ans_cnt, ans_code, ans_data} <= '0;
    end else if (resp_valid && resp_ready) begin
      {ans_cnt, ans_code, ans_data} <= {ans_cnt + 8'h1, resp_code, resp_data};
    end
  end
endmodule // fps_prog_sink
`default_nettype wire
